// [dv/test_tmr_timer16.sv]
`timescale 1ns/1ps
`include "tmr_defines.vh"

module test_tmr_timer16;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic ovf_ack = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, pin_a_i, pin_b_i, pin_a_o, pin_a_oe_n, pin_b_o, pin_b_oe_n;
    logic [31:0] rq;
    logic err_seen;
    logic exp_l;
    logic [1:0] c;
    integer n_mismatch = 0;
    integer n_compared = 0;
    integer hp;
    integer i;
    integer nv [5] = '{1, 8, 64, 256, 1024};

    tmr_timer16 dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ovf_ack(ovf_ack), .cmpa_ack(1'b0), .cmpb_ack(1'b0), .capt_ack(1'b0), .pin_a_i(pin_a_i),
        .pin_b_i(pin_b_i), .pin_a_o(pin_a_o), .pin_a_oe_n(pin_a_oe_n), .pin_b_o(pin_b_o), .pin_b_oe_n(pin_b_oe_n));
    tmr_pin_load load_a (.pin_o(pin_a_o), .pin_oe_n(pin_a_oe_n), .pin_i(pin_a_i));
    tmr_pin_load load_b (.pin_o(pin_b_o), .pin_oe_n(pin_b_oe_n), .pin_i(pin_b_i));

    initial begin
        forever #25 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task end_of_test;
        begin
            $display("compared %0d mismatches %0d", n_compared, n_mismatch);
            if (n_mismatch == 0 && n_compared > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        begin
            n_compared++;
            if (g !== e) begin
                n_mismatch++;
                $display("[ERR] %s expected %h seen %h", nm, e, g);
            end
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        integer k;
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            k = 0;
            @(posedge pclk);
            while (pready !== 1'b1 && k < 50) begin
                k++;
                @(posedge pclk);
            end
            rq = prdata;
            err_seen = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            if (k >= 50) begin
                n_mismatch++;
                end_of_test;
            end
        end
    endtask

    // Skips to one output edge, then counts clocks to the next.
    task meas(output integer n);
        logic p;
        begin
            repeat (2) begin
                p = pin_a_o;
                n = 0;
                while (pin_a_o === p && n < 5000) begin
                    // Sample mid-cycle so the registered pin has settled.
                    @(negedge pclk);
                    n++;
                end
            end
            if (n >= 5000) begin
                n_mismatch++;
                end_of_test;
            end
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `TMR_ADDR_CTRL, 0);
        chk("ctrl_reset", 32'h0, rq);
        apb(0, `TMR_ADDR_PORT, 0);
        chk("port_reset", 32'h0, rq);
        apb(0, 8'h20, 0);
        chk("unmapped_err", 32'h1, err_seen);
        exp_l = 1'b0;
        for (i = 0; i < 8; i++) begin
            c = (i * 3) % 4;
            apb(1, `TMR_ADDR_CTRL, {26'h0, c, 4'h0});
            apb(1, `TMR_ADDR_FORCE, 32'h1);
            exp_l = c == 2'h1 ? ~exp_l : c == 2'h2 ? 1'b0 : c == 2'h3 ? 1'b1 : exp_l;
            apb(0, `TMR_ADDR_PORT, 0);
            chk("latch_a", exp_l, rq[6]);
        end
        apb(0, `TMR_ADDR_FLAGS, 0);
        chk("force_flags", 32'h0, rq);
        apb(0, `TMR_ADDR_CNT, 0);
        chk("force_cnt", 32'h0, rq);
        repeat (2) @(posedge pclk);
        chk("pin_input", 1'b1, pin_a_oe_n);
        chk("pin_b_input", 1'b1, pin_b_oe_n);
        apb(1, `TMR_ADDR_PORT, 32'h4);
        repeat (4) @(posedge pclk);
        chk("pin_drive", 1'b0, pin_a_oe_n);
        chk("pin_latch", 1'b1, pin_a_o);
        apb(0, `TMR_ADDR_PORT, 0);
        chk("pin_level", 1'b1, rq[4]);
        apb(1, `TMR_ADDR_CTRL, 0);
        repeat (2) @(posedge pclk);
        chk("pin_port", 1'b0, pin_a_o);
        for (i = 0; i < 5; i++) begin
            apb(1, `TMR_ADDR_CMPA, 32'h1);
            apb(1, `TMR_ADDR_CNT, 32'h0);
            apb(1, `TMR_ADDR_FLAGS, 32'hF);
            apb(1, `TMR_ADDR_CTRL, ((i + 1) << 8) | 32'h14);
            meas(hp);
            chk("half_period", 2 * nv[i], hp);
            apb(1, `TMR_ADDR_CTRL, 0);
            apb(0, `TMR_ADDR_FLAGS, 0);
            chk("top_flag_a", 32'h2, rq & 32'hA);
        end
        apb(1, `TMR_ADDR_CAPT, 32'h2);
        apb(1, `TMR_ADDR_CNT, 32'h0);
        apb(1, `TMR_ADDR_FLAGS, 32'hF);
        apb(1, `TMR_ADDR_CTRL, 32'h11C);
        meas(hp);
        chk("capt_period", 32'h3, hp);
        apb(1, `TMR_ADDR_CTRL, 0);
        apb(0, `TMR_ADDR_FLAGS, 0);
        chk("top_flag_c", 32'h1, rq[3]);
        apb(1, `TMR_ADDR_CNT, 32'hFFFE);
        apb(1, `TMR_ADDR_FLAGS, 32'hF);
        apb(1, `TMR_ADDR_CTRL, 32'h100);
        repeat (6) @(posedge pclk);
        apb(1, `TMR_ADDR_CTRL, 0);
        apb(0, `TMR_ADDR_CNT, 0);
        chk("wrapped", 32'h1, rq[15:4] == 12'h0);
        apb(0, `TMR_ADDR_FLAGS, 0);
        chk("ovf_set", 32'h1, rq[0]);
        @(posedge pclk);
        ovf_ack <= 1'b1;
        @(posedge pclk);
        ovf_ack <= 1'b0;
        apb(0, `TMR_ADDR_FLAGS, 0);
        chk("ovf_ack", 32'h0, rq[0]);
        apb(1, `TMR_ADDR_CMPA, 32'h8);
        apb(1, `TMR_ADDR_CNT, 32'h8);
        apb(1, `TMR_ADDR_FLAGS, 32'hF);
        apb(1, `TMR_ADDR_CTRL, 32'h100);
        repeat (6) @(posedge pclk);
        apb(1, `TMR_ADDR_CTRL, 0);
        apb(0, `TMR_ADDR_FLAGS, 0);
        chk("match_block", 32'h0, rq[1]);
        end_of_test;
    end
endmodule

// [dv/tmr_pin_load.sv]
`timescale 1ns/1ps

module tmr_pin_load (
    input wire logic pin_o,    // Value the block offers to the wire.
    input wire logic pin_oe_n, // Block drives the wire when low.
    output logic pin_i         // Level on the wire.
);
    // A weak pull-down holds the wire low once the block lets go of it.
    assign pin_i = pin_oe_n ? 1'b0 : pin_o;
endmodule

// [dv/tmr_timer16_properties.sv]
`timescale 1ns/1ps
`include "tmr_defines.vh"

module tmr_timer16_checker (
    input wire pclk,           // System clock.
    input wire presetn,        // Reset, active low.
    input wire psel,           // APB select.
    input wire penable,        // APB enable.
    input wire pwrite,         // APB direction.
    input wire [7:0] paddr,    // APB address.
    input wire [31:0] prdata,  // APB read data.
    input wire pready,         // APB ready.
    input wire pslverr,        // APB error.
    input wire pin_a_o,        // Pin A drive value.
    input wire pin_a_oe_n,     // Pin A enable.
    input wire pin_b_o,        // Pin B drive value.
    input wire pin_b_oe_n      // Pin B enable.
);
    wire rd_setup = psel && !penable && !pwrite;
    wire port_wr = psel && penable && pwrite && paddr == `TMR_ADDR_PORT;
    wire mapped = paddr[1:0] == 2'b00 && paddr < 8'h20;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    reset_pins_a: assert property ($rose(presetn) |-> !pin_a_o && !pin_b_o && pin_a_oe_n && pin_b_oe_n)
        else $error("compare pins not idle after reset");
    // Direction only moves after software writes the port register.
    dir_source_a: assert property (($changed(pin_a_oe_n) || $changed(pin_b_oe_n)) |->
        $past(port_wr) || $past(port_wr, 2))
        else $error("pin direction changed without a port write");
    force_read_a: assert property (rd_setup && paddr == `TMR_ADDR_FORCE |=> prdata == 32'h0)
        else $error("force strobe reads nonzero");
    count_width_a: assert property (rd_setup && paddr == `TMR_ADDR_CNT |=> prdata[31:16] == 16'h0)
        else $error("counter read wider than 16 bits");
    unmapped_read_a: assert property (rd_setup && !mapped |=> prdata == 32'h0 && pslverr)
        else $error("unmapped read not refused");
    read_hold_a: assert property (!rd_setup |=> $stable(prdata))
        else $error("read data moved without a read");
    slverr_map_a: assert property (pslverr == (psel && penable && !mapped))
        else $error("error response does not match address map");
    ready_high_a: assert property (pready)
        else $error("ready dropped");

    cover property (port_wr);
    cover property (rd_setup && paddr == `TMR_ADDR_FLAGS);
    cover property ($changed(pin_a_o) && !pin_a_oe_n);
endmodule

bind tmr_timer16 tmr_timer16_checker chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_a_o(pin_a_o),
    .pin_a_oe_n(pin_a_oe_n), .pin_b_o(pin_b_o), .pin_b_oe_n(pin_b_oe_n));

// [logic/tmr_timer16.v]
`timescale 1ns/1ps
`include "tmr_defines.vh"

module tmr_timer16 (
    input wire pclk,            // System clock, 20 MHz.
    input wire presetn,         // Asynchronous reset, active low.
    input wire psel,            // APB select.
    input wire penable,         // APB enable.
    input wire pwrite,          // APB direction, high for write.
    input wire [7:0] paddr,     // APB byte address.
    input wire [31:0] pwdata,   // APB write data.
    output reg [31:0] prdata,   // APB read data.
    output wire pready,         // APB ready.
    output wire pslverr,        // APB error for unmapped address.
    input wire ovf_ack,         // Overflow interrupt serviced, one-cycle pulse.
    input wire cmpa_ack,        // Compare A interrupt serviced, one-cycle pulse.
    input wire cmpb_ack,        // Compare B interrupt serviced, one-cycle pulse.
    input wire capt_ack,        // Capture interrupt serviced, one-cycle pulse.
    input wire pin_a_i,         // Level seen on compare pin A.
    input wire pin_b_i,         // Level seen on compare pin B.
    output reg pin_a_o,         // Drive value for compare pin A.
    output reg pin_a_oe_n,      // Pin A driven when low.
    output reg pin_b_o,         // Drive value for compare pin B.
    output reg pin_b_oe_n       // Pin B driven when low.
);

////////////////////////////////////////////////////////////////////////////////

    reg [3:0] waveform_mode_select_r;
    reg [1:0] compare_output_mode_a_r;
    reg [1:0] compare_output_mode_b_r;
    reg [2:0] clk_select_r;
    reg [15:0] counter_value_r;
    reg [15:0] compare_value_a_r;
    reg [15:0] compare_value_b_r;
    reg [15:0] capture_value_register_r;
    reg overflow_flag_r;
    reg compare_a_flag_r;
    reg compare_b_flag_r;
    reg capture_flag_r;
    reg compare_output_latch_a_r;
    reg compare_output_latch_b_r;
    reg [1:0] port_out_r;
    reg compare_pin_a_direction_bit_r;
    reg compare_pin_b_direction_bit_r;
    reg match_block_r;
    reg [9:0] presc_r;
    reg [2:0] pin_a_sync_r;
    reg [2:0] pin_b_sync_r;
    reg pin_a_level_r;
    reg pin_b_level_r;

    wire setup_ph;
    wire access_ph;
    wire wr_en;
    wire addr_ok;
    wire non_pwm;
    wire tick;
    wire ctc_mode;
    wire [15:0] top_val;
    wire match_a;
    wire match_b;
    wire match_capt;
    wire at_top;
    wire wrap;
    wire force_a;
    wire force_b;
    wire cnt_wr;
    reg [9:0] presc_last;
    reg [31:0] rd_mux;

////////////////////////////////////////////////////////////////////////////////

    // Latch value after a compare action; mode zero keeps it.
    function action;
        input [1:0] mode;
        input cur;
        begin
            case (mode)
                `TMR_COM_TOGGLE: action = ~cur;
                `TMR_COM_CLEAR: action = 1'b0;
                `TMR_COM_SET: action = 1'b1;
                default: action = cur;
            endcase
        end
    endfunction

    function is_mapped;
        input [7:0] a;
        begin
            case (a)
                `TMR_ADDR_CTRL, `TMR_ADDR_FORCE, `TMR_ADDR_CNT, `TMR_ADDR_CMPA,
                `TMR_ADDR_CMPB, `TMR_ADDR_CAPT, `TMR_ADDR_FLAGS, `TMR_ADDR_PORT: is_mapped = 1'b1;
                default: is_mapped = 1'b0;
            endcase
        end
    endfunction

////////////////////////////////////////////////////////////////////////////////
// APB slave: read data is captured in the setup cycle so the access cycle
// can finish at once while prdata still comes from a flip-flop.

    assign setup_ph = psel & ~penable;
    assign access_ph = psel & penable;
    assign addr_ok = is_mapped(paddr);
    assign pready = 1'b1;
    assign pslverr = access_ph & ~addr_ok;
    assign wr_en = access_ph & pwrite & addr_ok;
    assign cnt_wr = wr_en & (paddr == `TMR_ADDR_CNT);
    assign force_a = wr_en & (paddr == `TMR_ADDR_FORCE) & pwdata[0] & non_pwm;
    assign force_b = wr_en & (paddr == `TMR_ADDR_FORCE) & pwdata[1] & non_pwm;

    always @* begin
        rd_mux = 32'h00000000;
        case (paddr)
            `TMR_ADDR_CTRL: rd_mux = {21'h000000, clk_select_r, compare_output_mode_b_r,
                                      compare_output_mode_a_r, waveform_mode_select_r};
            `TMR_ADDR_CNT: rd_mux = {16'h0000, counter_value_r};
            `TMR_ADDR_CMPA: rd_mux = {16'h0000, compare_value_a_r};
            `TMR_ADDR_CMPB: rd_mux = {16'h0000, compare_value_b_r};
            `TMR_ADDR_CAPT: rd_mux = {16'h0000, capture_value_register_r};
            `TMR_ADDR_FLAGS: rd_mux = {28'h0000000, capture_flag_r, compare_b_flag_r,
                                       compare_a_flag_r, overflow_flag_r};
            `TMR_ADDR_PORT: rd_mux = {24'h000000, compare_output_latch_b_r, compare_output_latch_a_r,
                                      pin_b_level_r, pin_a_level_r, compare_pin_b_direction_bit_r,
                                      compare_pin_a_direction_bit_r, port_out_r};
            default: rd_mux = 32'h00000000;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup_ph & ~pwrite) begin
            prdata <= rd_mux;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Control, compare and port registers.

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            waveform_mode_select_r <= 4'h0;
            compare_output_mode_a_r <= 2'h0;
            compare_output_mode_b_r <= 2'h0;
            clk_select_r <= 3'h0;
            compare_value_a_r <= 16'h0000;
            compare_value_b_r <= 16'h0000;
            capture_value_register_r <= 16'h0000;
            port_out_r <= 2'h0;
            compare_pin_a_direction_bit_r <= 1'b0;
            compare_pin_b_direction_bit_r <= 1'b0;
        end else if (wr_en) begin
            case (paddr)
                `TMR_ADDR_CTRL: begin
                    // Mode held, used at next match.
                    waveform_mode_select_r <= pwdata[`TMR_CTRL_WGM_LSB +: 4];
                    compare_output_mode_a_r <= pwdata[`TMR_CTRL_COMA_LSB +: 2];
                    compare_output_mode_b_r <= pwdata[`TMR_CTRL_COMB_LSB +: 2];
                    clk_select_r <= pwdata[`TMR_CTRL_CS_LSB +: 3];
                end
                `TMR_ADDR_CMPA: compare_value_a_r <= pwdata[15:0];
                `TMR_ADDR_CMPB: compare_value_b_r <= pwdata[15:0];
                `TMR_ADDR_CAPT: capture_value_register_r <= pwdata[15:0];
                `TMR_ADDR_PORT: begin
                    port_out_r <= pwdata[1:0];
                    compare_pin_a_direction_bit_r <= pwdata[2];
                    compare_pin_b_direction_bit_r <= pwdata[3];
                end
                default: begin
                end
            endcase
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Prescaler on the system clock. Stopped selection gives no ticks.

    always @* begin
        case (clk_select_r)
            `TMR_CS_DIV1: presc_last = 10'd0;
            `TMR_CS_DIV8: presc_last = 10'd7;
            `TMR_CS_DIV64: presc_last = 10'd63;
            `TMR_CS_DIV256: presc_last = 10'd255;
            `TMR_CS_DIV1024: presc_last = 10'd1023;
            default: presc_last = 10'd0;
        endcase
    end

    assign tick = (clk_select_r >= `TMR_CS_DIV1) && (clk_select_r <= `TMR_CS_DIV1024) &&
                  (presc_r >= presc_last);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_r <= 10'd0;
        end else if (tick || clk_select_r == `TMR_CS_STOP) begin
            presc_r <= 10'd0;
        end else begin
            presc_r <= presc_r + 10'd1;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Counter. The value compared at a tick is the one held through the timer
// cycle just ended, so a match is acted on at the next timer clock.

    assign non_pwm = (waveform_mode_select_r == `TMR_WGM_NORMAL) ||
                     (waveform_mode_select_r == `TMR_WGM_CTC_A) ||
                     (waveform_mode_select_r == `TMR_WGM_CTC_CAPT);
    assign ctc_mode = (waveform_mode_select_r == `TMR_WGM_CTC_A) ||
                      (waveform_mode_select_r == `TMR_WGM_CTC_CAPT);
    assign top_val = (waveform_mode_select_r == `TMR_WGM_CTC_CAPT) ? capture_value_register_r
                                                                    : compare_value_a_r;
    assign match_a = tick & ~match_block_r & (counter_value_r == compare_value_a_r);
    assign match_b = tick & ~match_block_r & (counter_value_r == compare_value_b_r);
    assign match_capt = tick & ~match_block_r & (counter_value_r == capture_value_register_r);
    assign at_top = ctc_mode & tick & ~match_block_r & (counter_value_r == top_val);
    assign wrap = tick & ~cnt_wr & (counter_value_r == `TMR_CNT_MAX);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_value_r <= 16'h0000;
            match_block_r <= 1'b0;
        end else begin
            if (cnt_wr) begin
                counter_value_r <= pwdata[15:0];
            end else if (at_top) begin
                counter_value_r <= `TMR_CNT_ZERO;
            end else if (tick) begin
                counter_value_r <= counter_value_r + 16'h0001;
            end
            // Block one timer cycle, even stopped.
            if (cnt_wr) begin
                match_block_r <= 1'b1;
            end else if (tick) begin
                match_block_r <= 1'b0;
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Flags: hardware set wins over software or service clear.

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_flag_r <= 1'b0;
            compare_a_flag_r <= 1'b0;
            compare_b_flag_r <= 1'b0;
            capture_flag_r <= 1'b0;
        end else begin
            if (wrap) begin
                overflow_flag_r <= 1'b1;
            end else if (ovf_ack || (wr_en && paddr == `TMR_ADDR_FLAGS && pwdata[`TMR_FLAG_OVF])) begin
                overflow_flag_r <= 1'b0;
            end
            if (match_a) begin
                compare_a_flag_r <= 1'b1;
            end else if (cmpa_ack || (wr_en && paddr == `TMR_ADDR_FLAGS && pwdata[`TMR_FLAG_CMPA])) begin
                compare_a_flag_r <= 1'b0;
            end
            if (match_b) begin
                compare_b_flag_r <= 1'b1;
            end else if (cmpb_ack || (wr_en && paddr == `TMR_ADDR_FLAGS && pwdata[`TMR_FLAG_CMPB])) begin
                compare_b_flag_r <= 1'b0;
            end
            // Capture flag when it sets top.
            if (match_capt && waveform_mode_select_r == `TMR_WGM_CTC_CAPT) begin
                capture_flag_r <= 1'b1;
            end else if (capt_ack || (wr_en && paddr == `TMR_ADDR_FLAGS && pwdata[`TMR_FLAG_CAPT])) begin
                capture_flag_r <= 1'b0;
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Compare output latches. A force acts like a match on the latch alone.

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_output_latch_a_r <= 1'b0;
            compare_output_latch_b_r <= 1'b0;
        end else begin
            if (match_a || force_a) begin
                compare_output_latch_a_r <= action(compare_output_mode_a_r, compare_output_latch_a_r);
            end
            if (match_b || force_b) begin
                compare_output_latch_b_r <= action(compare_output_mode_b_r, compare_output_latch_b_r);
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Pin side. Input levels pass three stages; a level counts once the last
// two agree, so a single metastable sample never reaches the readback.

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_a_sync_r <= 3'b000;
            pin_b_sync_r <= 3'b000;
            pin_a_level_r <= 1'b0;
            pin_b_level_r <= 1'b0;
        end else begin
            pin_a_sync_r <= {pin_a_sync_r[1:0], pin_a_i};
            pin_b_sync_r <= {pin_b_sync_r[1:0], pin_b_i};
            if (pin_a_sync_r[1] == pin_a_sync_r[2]) begin
                pin_a_level_r <= pin_a_sync_r[2];
            end
            if (pin_b_sync_r[1] == pin_b_sync_r[2]) begin
                pin_b_level_r <= pin_b_sync_r[2];
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_a_o <= 1'b0;
            pin_b_o <= 1'b0;
            pin_a_oe_n <= 1'b1;
            pin_b_oe_n <= 1'b1;
        end else begin
            pin_a_o <= (|compare_output_mode_a_r) ? compare_output_latch_a_r : port_out_r[0];
            pin_b_o <= (|compare_output_mode_b_r) ? compare_output_latch_b_r : port_out_r[1];
            pin_a_oe_n <= ~compare_pin_a_direction_bit_r;
            pin_b_oe_n <= ~compare_pin_b_direction_bit_r;
        end
    end

endmodule

// [shared/tmr_defines.vh]
`ifndef TMR_DEFINES_VH
`define TMR_DEFINES_VH

`define TMR_ADDR_CTRL 8'h00
`define TMR_ADDR_FORCE 8'h04
`define TMR_ADDR_CNT 8'h08
`define TMR_ADDR_CMPA 8'h0C
`define TMR_ADDR_CMPB 8'h10
`define TMR_ADDR_CAPT 8'h14
`define TMR_ADDR_FLAGS 8'h18
`define TMR_ADDR_PORT 8'h1C

`define TMR_CTRL_WGM_LSB 0
`define TMR_CTRL_COMA_LSB 4
`define TMR_CTRL_COMB_LSB 6
`define TMR_CTRL_CS_LSB 8
`define TMR_CTRL_RESET 11'h000

`define TMR_FLAG_OVF 0
`define TMR_FLAG_CMPA 1
`define TMR_FLAG_CMPB 2
`define TMR_FLAG_CAPT 3

`define TMR_WGM_NORMAL 4'h0
`define TMR_WGM_CTC_A 4'h4
`define TMR_WGM_CTC_CAPT 4'hC

`define TMR_COM_NONE 2'h0
`define TMR_COM_TOGGLE 2'h1
`define TMR_COM_CLEAR 2'h2
`define TMR_COM_SET 2'h3

`define TMR_CS_STOP 3'h0
`define TMR_CS_DIV1 3'h1
`define TMR_CS_DIV8 3'h2
`define TMR_CS_DIV64 3'h3
`define TMR_CS_DIV256 3'h4
`define TMR_CS_DIV1024 3'h5

`define TMR_CNT_MAX 16'hFFFF
`define TMR_CNT_ZERO 16'h0000

`endif
